// ===== design/wbc_params.svh
// Constants for the window, branch and call control block.
// Assumes inclusion by the package and by the design modules only.
`ifndef WBC_PARAMS_SVH
`define WBC_PARAMS_SVH
`define WBC_NWIN_DEFAULT   8
`define WBC_COND_NEVER     4'h0
`define WBC_COND_ALWAYS    4'h8
`define WBC_LINK_REG       5'h0F
`define WBC_UDIV_SAT       32'hFFFFFFFF
`define WBC_SDIV_SAT_POS   32'h7FFFFFFF
`define WBC_SDIV_SAT_NEG   32'h80000000
`define WBC_BRANCH_DISPLACEMENT_MSB     21
`define WBC_CALL_DISPLACEMENT_MSB     29
`endif

// ===== design/wbc_pkg.sv
// Types for the window, branch and call control block.
// Assumes the params header sits beside it.
`include "wbc_params.svh"
package wbc_pkg;
    typedef enum logic [2:0] {
        WBC_OP_NONE    = 3'b000,
        WBC_OP_SAVE    = 3'b001,
        WBC_OP_RESTORE = 3'b010,
        WBC_OP_BICC    = 3'b011,
        WBC_OP_FP_COND_BRANCH   = 3'b100,
        WBC_OP_CALL    = 3'b101,
        WBC_OP_DIV     = 3'b110
    } wbc_op_t;
endpackage

// ===== design/wbc_cond_eval.sv
// Condition evaluator for integer and floating-point branch fields.
// Assumes a purely combinational caller on the same clock.
`include "wbc_params.svh"
module wbc_cond_eval
    import wbc_pkg::*;
(
    input  wire logic [3:0] cond_i,   // Branch condition field.
    input  wire logic       is_fp_i,  // High for a floating-point branch.
    input  wire logic [3:0] icc_i,    // Integer codes n,z,v,c.
    input  wire logic [1:0] fcc_i,    // FP code: 0 eq, 1 lt, 2 gt, 3 unordered.
    output logic            true_o    // Condition holds.
);
    logic n, z, v, c, fe, fl, fg, fu;
    logic lo;
    assign {n, z, v, c} = icc_i;
    assign fe = (fcc_i == 2'h0);
    assign fl = (fcc_i == 2'h1);
    assign fg = (fcc_i == 2'h2);
    assign fu = (fcc_i == 2'h3);

    always_comb begin
        lo = 1'b0;
        true_o = 1'b0;
        if (!is_fp_i) begin
            // The upper bit takes the complement of the lower-half test.
            unique case (cond_i[2:0])
                3'h0: lo = 1'b0;
                3'h1: lo = z;
                3'h2: lo = z | (n ^ v);
                3'h3: lo = n ^ v;
                3'h4: lo = c | z;
                3'h5: lo = c;
                3'h6: lo = n;
                3'h7: lo = v;
            endcase
            true_o = cond_i[3] ? ~lo : lo;
        end else begin
            unique case (cond_i)
                4'h0: true_o = 1'b0;
                4'h1: true_o = fl | fg | fu;
                4'h2: true_o = fl | fg;
                4'h3: true_o = fl | fu;
                4'h4: true_o = fl;
                4'h5: true_o = fg | fu;
                4'h6: true_o = fg;
                4'h7: true_o = fu;
                4'h8: true_o = 1'b1;
                4'h9: true_o = fe;
                4'hA: true_o = fe | fu;
                4'hB: true_o = fe | fg;
                4'hC: true_o = fe | fg | fu;
                4'hD: true_o = fe | fl;
                4'hE: true_o = fe | fl | fu;
                4'hF: true_o = fe | fl | fg;
            endcase
        end
    end
endmodule

// ===== design/wbc_control.sv
// Control-transfer, register-window and divide-outcome logic of the integer unit.
// Assumes one decoded instruction per cycle on op_i and a same-clock datapath.
// Behaviour
// - Save decrements pointer, overflow trap if masked.
// - Unmasked save writes new pointer, no trap.
// - Restore increments pointer, underflow trap if masked.
// - Untrapped save/restore adds, writes into new window.
// - Decode integer condition field, upper bit complements.
// - Branch-never: no transfer; annul bit suppresses delay.
// - Branch-always jumps pc plus four times displacement.
// - Taken conditional executes delay; untaken annulled suppresses it.
// - Decode floating-point condition against four flags.
// - FP branch-always jumps regardless of fp codes.
// - FP disabled or absent: trap, no branch/annul.
// - Call jumps pc plus displacement shifted by two.
// - Call writes its own address into register 15.
// - Divide cc sets overflow, always clears carry.
// - Divide overflow returns a saturated quotient.
`include "wbc_params.svh"
module wbc_control
    import wbc_pkg::*;
#(
    parameter int NWIN = `WBC_NWIN_DEFAULT  // window_count.
) (
    input  wire logic                    clk_i,            // Core clock.
    input  wire logic                    reset_i,          // Synchronous reset, high.
    input  wire logic                    valid_i,          // Instruction valid.
    input  wire wbc_op_t                 op_i,             // Decoded class.
    input  wire logic [31:0]             pc_i,             // Address of instruction.
    input  wire logic [3:0]              cond_i,           // Branch condition field.
    input  wire logic                    annul_i,          // Annul bit.
    input  wire logic [21:0]             branch_displacement_i,         // branch_displacement.
    input  wire logic [29:0]             call_displacement_i,         // call_displacement.
    input  wire logic [31:0]             src_a_i,          // Operand from old window.
    input  wire logic [31:0]             src_b_i,          // Second operand / divisor.
    input  wire logic [31:0]             y_i,              // Upper dividend word.
    input  wire logic                    div_signed_i,     // Signed divide.
    input  wire logic                    div_setcc_i,      // Divide writes codes.
    input  wire logic [NWIN-1:0]         wim_i,            // Invalid-window mask.
    input  wire logic [3:0]              icc_i,            // n,z,v,c.
    input  wire logic [1:0]              fcc_i,            // FP condition code.
    input  wire logic                    fpu_enable_bit_i, // FP enable bit.
    input  wire logic                    fpu_present_i,    // FPU fitted.
    output logic [$clog2(NWIN)-1:0]      cwp_o,            // current_window_pointer.
    output logic                         xfer_o,           // Delayed transfer taken.
    output logic [31:0]                  target_o,         // Transfer target.
    output logic                         annul_o,          // Delay slot annulled.
    output logic                         wr_en_o,          // Register write.
    output logic [4:0]                   wr_reg_o,         // 15 on call, else 0.
    output logic [$clog2(NWIN)-1:0]      wr_win_o,         // Window of the write.
    output logic [31:0]                  wr_data_o,        // Write data.
    output logic                         icc_wr_o,         // Codes written.
    output logic [3:0]                   icc_o,            // New codes n,z,v,c.
    output logic                         trap_wovf_o,      // Window overflow.
    output logic                         trap_wunf_o,      // Window underflow.
    output logic                         trap_fpdis_o,     // FP disabled.
    output logic                         trap_divz_o       // Division by zero.
);
    localparam int CW = $clog2(NWIN);
    localparam logic [CW-1:0] LAST = CW'(NWIN - 1);

    logic [CW-1:0] cwp_reg;
    logic [CW-1:0] cwp_dec, cwp_inc;
    logic          is_save, is_rest, is_bicc, is_fb, is_call, is_div;
    logic          fp_ok, cond_true, is_uncond;
    logic [31:0]   br_target, call_target;
    logic          divz;
    logic [63:0]   dividend, abs_dvd, uq;
    logic [31:0]   abs_dvs;
    logic          neg_res, dovf;
    logic [31:0]   quot;

    assign is_save = valid_i && (op_i == WBC_OP_SAVE);
    assign is_rest = valid_i && (op_i == WBC_OP_RESTORE);
    assign is_bicc = valid_i && (op_i == WBC_OP_BICC);
    assign is_fb   = valid_i && (op_i == WBC_OP_FP_COND_BRANCH);
    assign is_call = valid_i && (op_i == WBC_OP_CALL);
    assign is_div  = valid_i && (op_i == WBC_OP_DIV);

    // Wraps use the window count, not the pointer width, so odd counts work.
    assign cwp_dec = (cwp_reg == '0) ? LAST : cwp_reg - CW'(1);
    assign cwp_inc = (cwp_reg == LAST) ? '0 : cwp_reg + CW'(1);

    assign fp_ok = fpu_enable_bit_i && fpu_present_i;

    wbc_cond_eval u_cond (
        .cond_i  (cond_i),
        .is_fp_i (is_fb),
        .icc_i   (icc_i),
        .fcc_i   (fcc_i),
        .true_o  (cond_true)
    );

    assign is_uncond = (cond_i == `WBC_COND_ALWAYS) || (cond_i == `WBC_COND_NEVER);
    assign br_target = pc_i + {{8{branch_displacement_i[`WBC_BRANCH_DISPLACEMENT_MSB]}}, branch_displacement_i, 2'b00};
    assign call_target = pc_i + {call_displacement_i, 2'b00};

    // Divide: magnitudes, unsigned quotient, then sign and saturation.
    assign divz     = (src_b_i == 32'h0);
    assign dividend = {y_i, src_a_i};
    assign abs_dvd  = (div_signed_i && dividend[63]) ? 64'(-dividend) : dividend;
    assign abs_dvs  = (div_signed_i && src_b_i[31]) ? 32'(-src_b_i) : src_b_i;
    assign neg_res  = div_signed_i && (dividend[63] ^ src_b_i[31]);
    assign uq       = divz ? 64'h0 : abs_dvd / {32'h0, abs_dvs};

    always_comb begin
        dovf = 1'b0;
        quot = uq[31:0];
        if (!div_signed_i) begin
            dovf = (uq[63:32] != 32'h0);
            if (dovf) quot = `WBC_UDIV_SAT;
        end else if (neg_res) begin
            dovf = (uq > 64'h0000_0000_8000_0000);
            quot = dovf ? `WBC_SDIV_SAT_NEG : 32'(-uq[31:0]);
        end else begin
            dovf = (uq > 64'h0000_0000_7FFF_FFFF);
            if (dovf) quot = `WBC_SDIV_SAT_POS;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cwp_reg <= '0;
        end else if (is_save && !wim_i[cwp_dec]) begin
            cwp_reg <= cwp_dec;
        end else if (is_rest && !wim_i[cwp_inc]) begin
            cwp_reg <= cwp_inc;
        end
    end
    assign cwp_o = cwp_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xfer_o       <= 1'b0;
            target_o     <= 32'h0;
            annul_o      <= 1'b0;
            trap_fpdis_o <= 1'b0;
        end else begin
            xfer_o       <= 1'b0;
            annul_o      <= 1'b0;
            trap_fpdis_o <= 1'b0;
            if (is_call) begin
                xfer_o   <= 1'b1;
                target_o <= call_target;
            end else if (is_fb && !fp_ok) begin
                trap_fpdis_o <= 1'b1;
            end else if (is_bicc || is_fb) begin
                xfer_o   <= cond_true;
                target_o <= br_target;
                // Unconditional forms annul on the bit; conditional only when untaken.
                annul_o  <= is_uncond ? annul_i : (annul_i && !cond_true);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_en_o     <= 1'b0;
            wr_reg_o    <= 5'h0;
            wr_win_o    <= '0;
            wr_data_o   <= 32'h0;
            icc_wr_o    <= 1'b0;
            icc_o       <= 4'h0;
            trap_wovf_o <= 1'b0;
            trap_wunf_o <= 1'b0;
            trap_divz_o <= 1'b0;
        end else begin
            wr_en_o     <= 1'b0;
            // Only a call names the link register; a stale 15 must not follow it.
            wr_reg_o    <= 5'h0;
            icc_wr_o    <= 1'b0;
            trap_wovf_o <= is_save && wim_i[cwp_dec];
            trap_wunf_o <= is_rest && wim_i[cwp_inc];
            trap_divz_o <= is_div && divz;
            wr_win_o    <= cwp_reg;
            if ((is_save && !wim_i[cwp_dec]) || (is_rest && !wim_i[cwp_inc])) begin
                wr_en_o   <= 1'b1;
                wr_win_o  <= is_save ? cwp_dec : cwp_inc;
                wr_data_o <= src_a_i + src_b_i;
            end else if (is_call) begin
                wr_en_o   <= 1'b1;
                wr_reg_o  <= `WBC_LINK_REG;
                wr_data_o <= pc_i;
            end else if (is_div && !divz) begin
                wr_en_o   <= 1'b1;
                wr_data_o <= quot;
                if (div_setcc_i) begin
                    icc_wr_o <= 1'b1;
                    icc_o    <= {quot[31], quot == 32'h0, dovf, 1'b0};
                end
            end
        end
    end

    a_save_overflow: assert property (@(posedge clk_i) disable iff (reset_i)
        is_save && wim_i[cwp_dec] |=> trap_wovf_o && !wr_en_o && $stable(cwp_reg))
        else $error("save into masked window did not trap");
    a_save_update: assert property (@(posedge clk_i) disable iff (reset_i)
        is_save && !wim_i[cwp_dec] |=> cwp_reg == $past(cwp_dec) && !trap_wovf_o)
        else $error("save pointer not updated");
    a_restore_flow: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rest |=> trap_wunf_o == $past(wim_i[cwp_inc]))
        else $error("restore trap mismatch");
    a_window_add: assert property (@(posedge clk_i) disable iff (reset_i)
        (is_save && !wim_i[cwp_dec]) || (is_rest && !wim_i[cwp_inc])
        |=> wr_en_o && wr_win_o == cwp_reg && wr_data_o == $past(src_a_i + src_b_i))
        else $error("window add wrong");
    a_cond_annul: assert property (@(posedge clk_i) disable iff (reset_i)
        is_bicc && !is_uncond && cond_true |=> xfer_o && !annul_o)
        else $error("taken conditional annulled");
    a_never_branch: assert property (@(posedge clk_i) disable iff (reset_i)
        is_bicc && cond_i == `WBC_COND_NEVER |=> !xfer_o && annul_o == $past(annul_i))
        else $error("branch never wrong");
    a_fp_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
        is_fb && !fp_ok |=> trap_fpdis_o && !xfer_o && !annul_o)
        else $error("fp disabled branch acted");
    a_call_link: assert property (@(posedge clk_i) disable iff (reset_i)
        is_call |=> xfer_o && wr_reg_o == 5'h0F && wr_data_o == $past(pc_i))
        else $error("call link wrong");
    a_div_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        is_div && divz |=> trap_divz_o && !wr_en_o && !icc_wr_o)
        else $error("zero divisor wrote result");
    a_div_carry: assert property (@(posedge clk_i) disable iff (reset_i)
        is_div && !divz && div_setcc_i |=> icc_wr_o && !icc_o[0] && icc_o[1] == $past(dovf))
        else $error("divide codes wrong");
endmodule

// ===== tb/wbc_control_tb_top.sv
// Self-checking bench for the window, branch and call control block.
// Assumes the design package and control module are compiled first; one clock, no partner.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module wbc_control_tb_top
    import wbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // A window count that is not a power of two makes a careless wrap show.
    localparam int NW = 6;
    localparam int CW = $clog2(NW);
    // Floating-point condition table: per field, the set of flags {U,G,L,E} that make it true.
    localparam logic [63:0] FP_TBL = 64'h7B3D591F84C2A6E0;
    logic          clk_i = 1'b0, reset_i = 1'b1, valid_i = 1'b0, annul_i = 1'b0;
    wbc_op_t       op_i = WBC_OP_NONE;
    logic [31:0]   pc_i = 32'h0, src_a_i = 32'h0, src_b_i = 32'h0, y_i = 32'h0;
    logic [3:0]    cond_i = 4'h0, icc_i = 4'h0;
    logic [21:0]   branch_displacement_i = 22'h0;
    logic [29:0]   call_displacement_i = 30'h0;
    logic          div_signed_i = 1'b0, div_setcc_i = 1'b0;
    logic          fpu_enable_bit_i = 1'b1, fpu_present_i = 1'b1;
    logic [NW-1:0] wim_i = '0;
    logic [1:0]    fcc_i = 2'h0;
    logic [CW-1:0] cwp_o, wr_win_o, cwp_exp;
    logic          xfer_o, annul_o, wr_en_o, icc_wr_o;
    logic          trap_wovf_o, trap_wunf_o, trap_fpdis_o, trap_divz_o;
    logic [31:0]   target_o, wr_data_o;
    logic [4:0]    wr_reg_o;
    logic [3:0]    icc_o;
    int            err_total = 0;
    int            checks = 0;

    wbc_control #(.NWIN(NW)) i_wbc_control (
        .clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i), .op_i(op_i), .pc_i(pc_i),
        .cond_i(cond_i), .annul_i(annul_i), .branch_displacement_i(branch_displacement_i), .call_displacement_i(call_displacement_i),
        .src_a_i(src_a_i), .src_b_i(src_b_i), .y_i(y_i), .div_signed_i(div_signed_i),
        .div_setcc_i(div_setcc_i), .wim_i(wim_i), .icc_i(icc_i), .fcc_i(fcc_i),
        .fpu_enable_bit_i(fpu_enable_bit_i), .fpu_present_i(fpu_present_i),
        .cwp_o(cwp_o), .xfer_o(xfer_o), .target_o(target_o), .annul_o(annul_o),
        .wr_en_o(wr_en_o), .wr_reg_o(wr_reg_o), .wr_win_o(wr_win_o), .wr_data_o(wr_data_o),
        .icc_wr_o(icc_wr_o), .icc_o(icc_o), .trap_wovf_o(trap_wovf_o),
        .trap_wunf_o(trap_wunf_o), .trap_fpdis_o(trap_fpdis_o), .trap_divz_o(trap_divz_o));

    always #2 clk_i = ~clk_i;

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Caller has set the fields at a rising edge; the answer is sampled just after the next.
    task automatic issue(input wbc_op_t o);
        valid_i <= 1'b1;
        op_i    <= o;
        @(posedge clk_i);
        valid_i <= 1'b0;
        #1;
    endtask

    task automatic win_op(input wbc_op_t o, input int bit_set, input logic trap_exp);
        logic [CW-1:0] nw;
        nw = (o == WBC_OP_SAVE) ? CW'((cwp_exp + NW - 1) % NW) : CW'((cwp_exp + 1) % NW);
        @(posedge clk_i);
        wim_i   <= (bit_set >= 0) ? NW'(1) << bit_set : '0;
        src_a_i <= 32'h0000_0005;
        src_b_i <= 32'hFFFF_FFFE;
        issue(o);
        `CHK(trap_wovf_o, (o == WBC_OP_SAVE) && trap_exp)
        `CHK(trap_wunf_o, (o == WBC_OP_RESTORE) && trap_exp)
        `CHK(wr_en_o, !trap_exp)
        if (!trap_exp) begin
            cwp_exp = nw;
            `CHK(wr_win_o, nw)
            `CHK(wr_data_o, 32'h0000_0003)
        end
        `CHK(cwp_o, cwp_exp)
    endtask

    task automatic window_scenario();
        win_op(WBC_OP_SAVE, -1, 1'b0);     // Wraps from 0 to NW-1.
        win_op(WBC_OP_SAVE, 4, 1'b1);
        win_op(WBC_OP_RESTORE, 0, 1'b1);
        win_op(WBC_OP_RESTORE, -1, 1'b0);  // Wraps back to 0.
        win_op(WBC_OP_SAVE, NW - 1, 1'b1);
    endtask

    function automatic logic int_true(input logic [3:0] c, input logic [3:0] cc);
        logic r;
        case (c[2:0])
            3'h0: r = 1'b0;
            3'h1: r = cc[2];
            3'h2: r = cc[2] | (cc[3] ^ cc[1]);
            3'h3: r = cc[3] ^ cc[1];
            3'h4: r = cc[0] | cc[2];
            3'h5: r = cc[0];
            3'h6: r = cc[3];
            default: r = cc[1];
        endcase
        return c[3] ? ~r : r;
    endfunction

    task automatic branch(input logic fp, input logic [3:0] c, input logic [3:0] cc,
                          input logic a, input logic t);
        @(posedge clk_i);
        cond_i   <= c;
        icc_i    <= cc;
        fcc_i    <= cc[1:0];
        annul_i  <= a;
        pc_i     <= 32'h0000_4000;
        branch_displacement_i <= 22'h3FFFF0;
        issue(fp ? WBC_OP_FP_COND_BRANCH : WBC_OP_BICC);
        `CHK(xfer_o, t)
        `CHK(annul_o, (c[2:0] == 3'h0) ? a : (a && !t))
        if (t) `CHK(target_o, 32'h0000_3FC0)
    endtask

    task automatic branch_scenario();
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 4; k++) begin
                branch(1'b0, 4'(c), 4'(16'h8A50 >> (4 * k)), k[0],
                       int_true(4'(c), 4'(16'h8A50 >> (4 * k))));
                // The fp code arrives with the branch; no compare or state-word load precedes it.
                branch(1'b1, 4'(c), 4'(k), ~k[0], FP_TBL[4 * c + k]);
            end
        end
    endtask

    task automatic fp_off_scenario(input logic en, input logic pres);
        @(posedge clk_i);
        fpu_enable_bit_i <= en;
        fpu_present_i    <= pres;
        cond_i           <= 4'h8;
        annul_i          <= 1'b1;
        issue(WBC_OP_FP_COND_BRANCH);
        `CHK({trap_fpdis_o, xfer_o, annul_o}, 3'b100)
        @(posedge clk_i);
        fpu_enable_bit_i <= 1'b1;
        fpu_present_i    <= 1'b1;
    endtask

    task automatic call_scenario();
        @(posedge clk_i);
        pc_i      <= 32'h8000_0010;
        call_displacement_i  <= 30'h2000_0001;
        issue(WBC_OP_CALL);
        `CHK(xfer_o, 1'b1)
        `CHK(target_o, 32'h0000_0014)
        `CHK({wr_en_o, wr_reg_o, wr_data_o}, {1'b1, 5'h0F, 32'h8000_0010})
    endtask

    task automatic div_chk(input logic [31:0] y, a, b, input logic sg, cc,
                           input logic [31:0] q, input logic [3:0] icc_e);
        @(posedge clk_i);
        y_i          <= y;
        src_a_i      <= a;
        src_b_i      <= b;
        div_signed_i <= sg;
        div_setcc_i  <= cc;
        issue(WBC_OP_DIV);
        `CHK(trap_divz_o, b == 32'h0)
        `CHK(wr_en_o, b != 32'h0)
        `CHK(icc_wr_o, cc && b != 32'h0)
        if (b != 32'h0) `CHK(wr_data_o, q)
        if (b != 32'h0) `CHK(wr_reg_o, 5'h0)
        if (cc && b != 32'h0) `CHK(icc_o, icc_e)
    endtask

    task automatic div_scenario();
        div_chk(32'h1, 32'h0, 32'h1, 1'b0, 1'b1, 32'hFFFF_FFFF, 4'hA);
        div_chk(32'h0, 32'h8000_0000, 32'h1, 1'b1, 1'b1, 32'h7FFF_FFFF, 4'h2);
        div_chk(32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h1, 1'b1, 1'b1, 32'h8000_0000, 4'hA);
        div_chk(32'h0, 32'h64, 32'h7, 1'b0, 1'b1, 32'hE, 4'h0);
        div_chk(32'hFFFF_FFFF, 32'hFFFF_FFF9, 32'h2, 1'b1, 1'b1, 32'hFFFF_FFFD, 4'h8);
        div_chk(32'h1, 32'h0, 32'h1, 1'b0, 1'b0, 32'hFFFF_FFFF, 4'h0);
        div_chk(32'h0, 32'h64, 32'h0, 1'b1, 1'b1, 32'h0, 4'h0);
    endtask

    initial begin
        cwp_exp = '0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK({cwp_o, xfer_o, wr_en_o, trap_wovf_o}, '0)
        window_scenario();
        branch_scenario();
        fp_off_scenario(1'b0, 1'b1);
        fp_off_scenario(1'b1, 1'b0);
        call_scenario();
        div_scenario();
        end_of_test();
    end

    // A run far beyond the scenario length means something hung.
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        end_of_test();
    end
endmodule
